// ---- inc/phy_cfg_pkg.sv ----
// Constants for the DDR2 PHY configuration block
package phy_cfg_pkg;
    localparam logic [7:0]  ADDR_CALCFG1  = 8'h00;
    localparam logic [7:0]  ADDR_PADCON   = 8'h04;
    localparam logic [7:0]  ADDR_DLLR     = 8'h08;
    localparam logic [7:0]  ADDR_CLKDLY   = 8'h0C;
    localparam logic [31:0] MASK_CALCFG1  = 32'h0000_1F01;
    localparam logic [31:0] MASK_PADCON   = 32'h70FF_63FF;
    localparam logic [31:0] MASK_DLLR     = 32'hF7FF_FF00;
    localparam logic [31:0] MASK_CLKDLY   = 32'h0000_0007;
    localparam logic [31:0] RST_CALCFG1   = 32'h0000_0801;
    localparam logic [31:0] RST_PADCON    = 32'h5044_4041;
    localparam logic [31:0] RST_DLLR      = 32'h0400_0000;
    localparam logic [31:0] RST_CLKDLY    = 32'h0000_0000;
    localparam int DBL_POS      = 12;
    localparam int WL_LSB       = 8;
    localparam int CS0_POS      = 0;
    localparam int PRE_LSB      = 29;
    localparam int RCV_POS      = 28;
    localparam int PU_LSB       = 20;
    localparam int PD_LSB       = 16;
    localparam int RATE_POS     = 14;
    localparam int WCD_POS      = 13;
    localparam int IDLL_POS     = 9;
    localparam int EOE_POS      = 8;
    localparam int TPU_LSB      = 6;
    localparam int TPD_LSB      = 4;
    localparam int ACS_POS      = 3;
    localparam int DS_POS       = 2;
    localparam int TEN_POS      = 1;
    localparam int TSEL_POS     = 0;
    localparam int DST_LSB      = 28;
    localparam int RDIS_POS     = 26;
    localparam int RCNT_LSB     = 8;
    localparam int UP_POS       = 5;
    localparam int LO_POS       = 4;
    localparam int REF_INTERVAL = 16;
    localparam int RECAL_UNIT   = 256;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PRE_2    = 2'h0;
    localparam logic [1:0] PRE_1P5  = 2'h1;
    localparam logic [1:0] PRE_1    = 2'h2;
endpackage

// ---- rtl/phy_cfg.sv ----
// DDR2 PHY configuration, DLL recalibration and calibration status
`timescale 1ns/1ps
module phy_cfg #(
    parameter int REF_CYCLES = phy_cfg_pkg::REF_INTERVAL
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        calib_ack,
    input  wire logic        calib_request,
    input  wire logic        wr_burst_active,
    input  wire logic        wr_cmd_in,
    input  wire logic        calib_done,
    input  wire logic        upper_pass_in,
    input  wire logic        lower_pass_in,
    input  wire logic        delta_wr,
    input  wire logic [2:0]  delta_in,
    output logic             calib_continue,
    output logic             calib_cs0_run,
    output logic [3:0]       write_latency_cycles,
    output logic [1:0]       write_preamble_length,
    output logic [2:0]       preamble_half_cycles,
    output logic             pad_receiver_on,
    output logic [3:0]       pullup_driver_strength,
    output logic [3:0]       pulldown_driver_strength,
    output logic             controller_rate_select,
    output logic             wr_cmd_out,
    output logic             internal_dll_select,
    output logic             pad_oe,
    output logic [1:0]       termination_pullup_code,
    output logic [1:0]       termination_pulldown_code,
    output logic             addr_ctrl_pad_strength,
    output logic             data_pad_strength,
    output logic             termination_enable,
    output logic             termination_value_select,
    output logic [3:0]       dll_delay_start_value,
    output logic             dll_recal_req,
    output logic [2:0]       lane_clock_delay_delta,
    output logic             upper_lane_calib_pass,
    output logic             lower_lane_calib_pass
);
    logic [31:0] cfg1_q;
    logic [31:0] pad_q;
    logic [31:0] dll_q;
    logic [2:0]  delta_q;
    logic        up_q;
    logic        lo_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_d;
    logic        hit;
    logic        burst_d1_q;
    logic        burst_cmd_q;
    localparam int REF_WAIT1 = REF_CYCLES + 1;
    localparam int REF_WAIT2 = 2 * REF_CYCLES + 1;

    ////////////////////////////////////////////////////////////////////
    // Bus slave, zero wait states
    assign hit = hsel && hready && (htrans == phy_cfg_pkg::HTRANS_NONSEQ);

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= hit && hwrite;
            if (hit) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    // Address phase read mux, forwards a write still in its data phase
    always_comb begin
        unique case (haddr[7:0])
            phy_cfg_pkg::ADDR_CALCFG1: rdata_d = cfg1_q;
            phy_cfg_pkg::ADDR_PADCON:  rdata_d = pad_q;
            phy_cfg_pkg::ADDR_DLLR:    rdata_d = dll_q;
            phy_cfg_pkg::ADDR_CLKDLY:  rdata_d = {26'h0, up_q, lo_q,
                                                  1'b0, delta_q};
            default:                   rdata_d = 32'h0000_0000;
        endcase
        if (wr_pend_q && wr_addr_q == haddr[7:0]) begin
            unique case (wr_addr_q)
                phy_cfg_pkg::ADDR_CALCFG1:
                    rdata_d = hwdata & phy_cfg_pkg::MASK_CALCFG1;
                phy_cfg_pkg::ADDR_PADCON:
                    rdata_d = hwdata & phy_cfg_pkg::MASK_PADCON;
                phy_cfg_pkg::ADDR_DLLR:
                    rdata_d = hwdata & phy_cfg_pkg::MASK_DLLR;
                phy_cfg_pkg::ADDR_CLKDLY:
                    rdata_d = {26'h0, up_q, lo_q, 1'b0, hwdata[2:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers, masked writes
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg1_q <= phy_cfg_pkg::RST_CALCFG1;
            pad_q  <= phy_cfg_pkg::RST_PADCON;
            dll_q  <= phy_cfg_pkg::RST_DLLR;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                phy_cfg_pkg::ADDR_CALCFG1:
                    cfg1_q <= hwdata & phy_cfg_pkg::MASK_CALCFG1;
                phy_cfg_pkg::ADDR_PADCON:
                    pad_q <= hwdata & phy_cfg_pkg::MASK_PADCON;
                phy_cfg_pkg::ADDR_DLLR:
                    dll_q <= hwdata & phy_cfg_pkg::MASK_DLLR;
                default: ;
            endcase
        end
    end

    // Delta: software write wins the cycle, else calibration update
    always_ff @(posedge clk) begin
        if (rst) begin
            delta_q <= 3'h0;
        end else if (wr_pend_q && wr_addr_q == phy_cfg_pkg::ADDR_CLKDLY) begin
            delta_q <= hwdata[2:0];
        end else if (delta_wr) begin
            delta_q <= delta_in;
        end
    end

    // Pass flags, shared status with the clock delay register
    always_ff @(posedge clk) begin
        if (rst) begin
            up_q <= 1'b0;
            lo_q <= 1'b0;
        end else if (calib_done) begin
            up_q <= upper_pass_in;
            lo_q <= lower_pass_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pad and configuration outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            write_latency_cycles      <= 4'h0;
            write_preamble_length     <= 2'h0;
            preamble_half_cycles      <= 3'h4;
            pad_receiver_on           <= 1'b0;
            pullup_driver_strength    <= 4'h0;
            pulldown_driver_strength  <= 4'h0;
            controller_rate_select    <= 1'b0;
            internal_dll_select       <= 1'b0;
            termination_pullup_code   <= 2'h0;
            termination_pulldown_code <= 2'h0;
            addr_ctrl_pad_strength    <= 1'b0;
            data_pad_strength         <= 1'b0;
            termination_enable        <= 1'b0;
            termination_value_select  <= 1'b0;
            dll_delay_start_value     <= 4'h0;
            lane_clock_delay_delta    <= 3'h0;
            upper_lane_calib_pass     <= 1'b0;
            lower_lane_calib_pass     <= 1'b0;
        end else begin
            write_latency_cycles <= cfg1_q[phy_cfg_pkg::WL_LSB +: 4];
            write_preamble_length <= pad_q[phy_cfg_pkg::PRE_LSB +: 2];
            unique case (pad_q[phy_cfg_pkg::PRE_LSB +: 2])
                phy_cfg_pkg::PRE_2:   preamble_half_cycles <= 3'h4;
                phy_cfg_pkg::PRE_1P5: preamble_half_cycles <= 3'h3;
                phy_cfg_pkg::PRE_1:   preamble_half_cycles <= 3'h2;
                default:              preamble_half_cycles <= 3'h4;
            endcase
            pad_receiver_on <= pad_q[phy_cfg_pkg::RCV_POS];
            pullup_driver_strength <= pad_q[phy_cfg_pkg::PU_LSB +: 4];
            pulldown_driver_strength <= pad_q[phy_cfg_pkg::PD_LSB +: 4];
            controller_rate_select <= pad_q[phy_cfg_pkg::RATE_POS];
            internal_dll_select <= pad_q[phy_cfg_pkg::IDLL_POS];
            termination_pullup_code <= pad_q[phy_cfg_pkg::TPU_LSB +: 2];
            termination_pulldown_code <= pad_q[phy_cfg_pkg::TPD_LSB +: 2];
            addr_ctrl_pad_strength <= pad_q[phy_cfg_pkg::ACS_POS];
            data_pad_strength <= pad_q[phy_cfg_pkg::DS_POS];
            termination_enable <= pad_q[phy_cfg_pkg::TEN_POS];
            termination_value_select <= pad_q[phy_cfg_pkg::TSEL_POS];
            dll_delay_start_value <= dll_q[phy_cfg_pkg::DST_LSB +: 4];
            lane_clock_delay_delta <= delta_q;
            upper_lane_calib_pass <= up_q;
            lower_lane_calib_pass <= lo_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write command delay and extra output enable cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_cmd_out <= 1'b0;
            pad_oe     <= 1'b0;
            burst_d1_q <= 1'b0;
        end else begin
            // Command is always registered; delay bit adds one more stage
            burst_d1_q <= wr_burst_active;
            if (pad_q[phy_cfg_pkg::WCD_POS]) begin
                wr_cmd_out <= burst_cmd_q;
            end else begin
                wr_cmd_out <= wr_cmd_in;
            end
            pad_oe <= wr_burst_active || (pad_q[phy_cfg_pkg::EOE_POS]
                      && burst_d1_q);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            burst_cmd_q <= 1'b0;
        end else begin
            burst_cmd_q <= wr_cmd_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Calibration acknowledge wait, one or two intervals
    logic [15:0] ref_cnt_q;
    logic        ref_busy_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_cnt_q      <= 16'h0000;
            ref_busy_q     <= 1'b0;
            calib_continue <= 1'b0;
        end else begin
            calib_continue <= 1'b0;
            if (calib_ack && !ref_busy_q) begin
                ref_busy_q <= 1'b1;
                ref_cnt_q  <= cfg1_q[phy_cfg_pkg::DBL_POS]
                    ? 16'(2 * REF_CYCLES - 1)
                    : 16'(REF_CYCLES - 1);
            end else if (ref_busy_q) begin
                if (ref_cnt_q == 16'h0000) begin
                    ref_busy_q     <= 1'b0;
                    calib_continue <= 1'b1;
                end else begin
                    ref_cnt_q <= ref_cnt_q - 16'h0001;
                end
            end
        end
    end

    // Chip select 0 calibration gating
    always_ff @(posedge clk) begin
        if (rst) begin
            calib_cs0_run <= 1'b0;
        end else begin
            calib_cs0_run <= calib_request
                && cfg1_q[phy_cfg_pkg::CS0_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // DLL recalibration period counter
    logic [25:0] recal_cnt_q;
    logic        first_done_q;
    logic [25:0] period;
    assign period = {dll_q[phy_cfg_pkg::RCNT_LSB +: 18], 8'h00};

    always_ff @(posedge clk) begin
        if (rst) begin
            recal_cnt_q   <= 26'h0000000;
            first_done_q  <= 1'b0;
            dll_recal_req <= 1'b0;
        end else begin
            dll_recal_req <= 1'b0;
            if (!first_done_q) begin
                first_done_q  <= 1'b1;
                dll_recal_req <= 1'b1;
                recal_cnt_q   <= period;
            end else if (!dll_q[phy_cfg_pkg::RDIS_POS]) begin
                if (recal_cnt_q <= 26'h0000001) begin
                    dll_recal_req <= 1'b1;
                    recal_cnt_q   <= period;
                end else begin
                    recal_cnt_q <= recal_cnt_q - 26'h0000001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data register, loaded as the address phase is taken
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hit && !hwrite) begin
            hrdata <= rdata_d;
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_cs0_gate: assert property (@(posedge clk) disable iff (rst)
        calib_cs0_run |-> $past(cfg1_q[0]))
        else $error("cs0 calibration ran while disabled");
    a_extra_oe: assert property (@(posedge clk) disable iff (rst)
        $fell(burst_d1_q) && pad_q[8] && $past(pad_q[8]) |-> pad_oe)
        else $error("extra output enable cycle missing");
    a_no_extra: assert property (@(posedge clk) disable iff (rst)
        !pad_q[8] && !$past(pad_q[8]) && !$past(wr_burst_active)
        |-> !pad_oe) else $error("output enable held");
    a_recal_off: assert property (@(posedge clk) disable iff (rst)
        first_done_q && $past(first_done_q) && $past(dll_q[26])
        |-> !dll_recal_req) else $error("recal while disabled");
    a_delta_sw: assert property (@(posedge clk) disable iff (rst)
        wr_pend_q && wr_addr_q == 8'h0C |=> delta_q == $past(hwdata[2:0]))
        else $error("delta write lost");
    a_pass_mirror: assert property (@(posedge clk) disable iff (rst)
        calib_done |=> up_q == $past(upper_pass_in)
        && lo_q == $past(lower_pass_in))
        else $error("pass flags not updated");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (pad_q & ~32'h70FF_63FF) == 32'h0 && (cfg1_q & ~32'h1F01) == 32'h0)
        else $error("reserved bit set");
    a_ref_single: assert property (@(posedge clk) disable iff (rst)
        calib_ack && !ref_busy_q && !cfg1_q[12] |-> ##REF_WAIT1 calib_continue)
        else $error("single interval wrong");
    a_ref_double: assert property (@(posedge clk) disable iff (rst)
        calib_ack && !ref_busy_q && cfg1_q[12] |-> ##REF_WAIT2 calib_continue)
        else $error("double interval wrong");
    a_wl_out: assert property (@(posedge clk) disable iff (rst)
        write_latency_cycles == $past(cfg1_q[11:8]) || $past(rst))
        else $error("write latency mismatch");
    a_read_zero: assert property (@(posedge clk)
        disable iff (rst) hit && !hwrite && haddr[7:0] == 8'h0C
        |=> hrdata[31:6] == 26'h0 && !hrdata[3])
        else $error("clock delay reserved bits set");
    a_read_fwd: assert property (@(posedge clk)
        disable iff (rst) hit && !hwrite && wr_pend_q
        && wr_addr_q == 8'h04 && haddr[7:0] == 8'h04 |=> hrdata == pad_q)
        else $error("read after write returned stale data");
    a_preamble_map: assert property (@(posedge clk)
        disable iff (rst) !$past(rst) && $past(pad_q[30:29]) == 2'h1
        |-> preamble_half_cycles == 3'h3)
        else $error("preamble length code wrong");
    a_rx_follow: assert property (@(posedge clk)
        disable iff (rst) !$past(rst)
        |-> pad_receiver_on == $past(pad_q[28]))
        else $error("receiver enable mismatch");
    a_dll_start: assert property (@(posedge clk)
        disable iff (rst) !$past(rst)
        |-> dll_delay_start_value == $past(dll_q[31:28]))
        else $error("dll start value mismatch");
    a_cs0_run: assert property (@(posedge clk)
        disable iff (rst) calib_request && cfg1_q[0] |=> calib_cs0_run)
        else $error("cs0 calibration not run while enabled");
    c_recal: cover property (@(posedge clk) disable iff (rst)
        first_done_q && dll_recal_req);
    c_double: cover property (@(posedge clk) disable iff (rst)
        cfg1_q[12] && calib_continue);
    c_extra: cover property (@(posedge clk) disable iff (rst)
        pad_oe && !wr_burst_active);
    c_delta_hw: cover property (@(posedge clk) disable iff (rst)
        delta_wr);
    c_fwd_read: cover property (@(posedge clk) disable iff (rst)
        hit && !hwrite && wr_pend_q && wr_addr_q == haddr[7:0]);
endmodule

// ---- verification/calib_partner.sv ----
// Calibration engine and lane status model at the far side
`timescale 1ns/1ps
module calib_partner (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [3:0] lat,
    input  wire logic [1:0] pass_pat,
    input  wire logic [2:0] dval,
    output logic            ack,
    output logic            done,
    output logic            up_pass,
    output logic            lo_pass,
    output logic            dwr,
    output logic [2:0]      dout
);
    initial begin
        ack = 1'b0;
        done = 1'b0;
        dwr = 1'b0;
        {up_pass, lo_pass} = 2'h1;
        dout = 3'h5;
        forever begin
            @(posedge clk);
            if (run) begin
                repeat (lat) @(posedge clk);
                ack <= 1'b1;
                @(posedge clk);
                ack <= 1'b0;
                done <= 1'b1;
                {up_pass, lo_pass} <= pass_pat;
                dwr <= 1'b1;
                dout <= dval;
                @(posedge clk);
                done <= 1'b0;
                dwr <= 1'b0;
                {up_pass, lo_pass} <= ~pass_pat;
                dout <= ~dval;
                while (run) @(posedge clk);
            end
        end
    end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the PHY configuration block
`timescale 1ns/1ps
module testbench;
    localparam int REF = 4;
    logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, v, r, e, g;
    logic [1:0]  htrans, pass_pat, pre, tpu, tpd;
    logic [2:0]  hsize, dval, delta, din, pre_half;
    logic [3:0]  lat, wl, wl_o, pu, pd, dst;
    logic        calib_request, wr_burst_active, wr_cmd_in, ack, done;
    logic        up_in, lo_in, dwr, cont, cs0_run, wcmd_out, oe, recal;
    logic        up_pass, lo_pass, rcv, rate, idll, acs, dps, ten, tsel;
    logic [31:0] adr[4], msk[4], rstv[4], exp_q[$], got_q[$];
    string       nm_q[$];
    int          err_total, tests_run, i, n, m, k;
    assign hready = hreadyout;
    phy_cfg #(.REF_CYCLES(REF)) phy_cfg_i (
        .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
        .hwdata, .hrdata, .hreadyout, .hresp, .calib_ack(ack),
        .calib_request, .wr_burst_active, .wr_cmd_in, .calib_done(done),
        .upper_pass_in(up_in), .lower_pass_in(lo_in), .delta_wr(dwr),
        .delta_in(din), .calib_continue(cont), .calib_cs0_run(cs0_run),
        .write_latency_cycles(wl_o), .write_preamble_length(pre),
        .preamble_half_cycles(pre_half), .pad_receiver_on(rcv),
        .pullup_driver_strength(pu), .pulldown_driver_strength(pd),
        .controller_rate_select(rate), .wr_cmd_out(wcmd_out),
        .internal_dll_select(idll), .pad_oe(oe),
        .termination_pullup_code(tpu), .termination_pulldown_code(tpd),
        .addr_ctrl_pad_strength(acs), .data_pad_strength(dps),
        .termination_enable(ten), .termination_value_select(tsel),
        .dll_delay_start_value(dst), .dll_recal_req(recal),
        .lane_clock_delay_delta(delta), .upper_lane_calib_pass(up_pass),
        .lower_lane_calib_pass(lo_pass)
    );
    calib_partner calib_partner_i (
        .clk, .run(cs0_run), .lat, .pass_pat, .dval, .ack, .done,
        .up_pass(up_in), .lo_pass(lo_in), .dwr, .dout(din)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        repeat (2) @(negedge clk);
        $display("counts: %0d checks, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tmo(input int c, input int lim);
        if (c >= lim) begin
            err_total++;
            $display("unexpected wait: expected below %0d, seen %0d", lim, c);
            summarize();
        end
    endtask
    task automatic chk(input string s, input logic [31:0] ev, gv);
        exp_q.push_back(ev);
        nm_q.push_back(s);
        got_q.push_back(gv);
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        int c;
        haddr <= a;
        hsel <= 1'b1;
        hwrite <= w;
        htrans <= phy_cfg_pkg::HTRANS_NONSEQ;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (hreadyout !== 1'b1 && c < 50);
        tmo(c, 50);
        htrans <= 2'h0;
        hwdata <= d;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (hreadyout !== 1'b1 && c < 50);
        tmo(c, 50);
        r = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, ev, input string s);
        bus(1'b0, a, 32'h0);
        chk(s, ev, r);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        string s;
        logic [31:0] ex, gt;
        forever begin
            @(negedge clk);
            while (got_q.size() != 0) begin
                s = nm_q.pop_front();
                ex = exp_q.pop_front();
                gt = got_q.pop_front();
                tests_run++;
                if (gt !== ex) begin
                    err_total++;
                    $display("unexpected %s: expected %h, seen %h", s, ex, gt);
                end
            end
        end
    end
    initial begin
        rst = 1'b1;
        {hsel, htrans, haddr, hwrite, hwdata} = 68'h0;
        {calib_request, wr_burst_active, wr_cmd_in} = 3'h0;
        {lat, pass_pat, dval} = 9'h0;
        hsize = 3'h2;
        err_total = 0;
        tests_run = 0;
        adr = '{32'h0, 32'h4, 32'h8, 32'hC};
        msk = '{phy_cfg_pkg::MASK_CALCFG1, phy_cfg_pkg::MASK_PADCON,
                phy_cfg_pkg::MASK_DLLR, phy_cfg_pkg::MASK_CLKDLY};
        rstv = '{phy_cfg_pkg::RST_CALCFG1, phy_cfg_pkg::RST_PADCON,
                 phy_cfg_pkg::RST_DLLR, phy_cfg_pkg::RST_CLKDLY};
        v = $urandom(32);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 4; k++) rd(adr[k], rstv[k], "reset");
        rd(32'h10, 32'h0, "unmapped");
        for (k = 0; k < 4; k++) begin
            v = $urandom();
            if (k == 1) v[30] = 1'b0;
            if (k == 2) v[26] = 1'b1;
            bus(1'b1, adr[k], v);
            rd(adr[k], v & msk[k], "readback");
        end
        chk("response", 32'h0, {31'h0, hresp});
        $display("test registers done");
        for (k = 0; k < 3; k++) begin
            v = $urandom();
            v[30:29] = k[1:0];
            bus(1'b1, adr[1], v);
            repeat (2) @(posedge clk);
            e = {v[30:28], v[23:16], v[14], v[9]};
            g = {pre, rcv, pu, pd, rate, idll};
            chk("drive", e, g);
            chk("term", v[7:0], {tpu, tpd, acs, dps, ten, tsel});
            chk("preamble", 4 - k, pre_half);
        end
        $display("test pad fields done");
        wl = 4'($urandom());
        bus(1'b1, adr[0], {20'h0, wl, 8'h00});
        calib_request <= 1'b1;
        repeat (4) @(posedge clk);
        chk("latency", wl, wl_o);
        chk("cs0 off", 32'h0, cs0_run);
        calib_request <= 1'b0;
        for (k = 0; k < 2; k++) begin
            lat <= 4'(3 + 7 * k);
            pass_pat <= 2'(k + 1);
            dval <= 3'(6 - 3 * k);
            bus(1'b1, adr[0], {19'h0, k[0], wl, 8'h01});
            calib_request <= 1'b1;
            for (i = 0; i < 60 && ack !== 1'b1; i++) @(posedge clk);
            tmo(i, 60);
            for (n = 0; n < 100 && cont !== 1'b1; n++) @(posedge clk);
            tmo(n, 100);
            calib_request <= 1'b0;
            if (k == 0) m = n;
            repeat (4) @(posedge clk);
            rd(adr[3], {26'h0, pass_pat, 1'b0, dval}, "lane");
            chk("pass", pass_pat, {up_pass, lo_pass});
        end
        chk("doubled wait", REF, n - m);
        bus(1'b1, adr[3], 32'hFFFF_FFFD);
        rd(adr[3], {26'h0, pass_pat, 4'h5}, "sw delta");
        chk("delta", 32'h5, delta);
        $display("test calibration done");
        for (k = 0; k < 2; k++) begin
            bus(1'b1, adr[1], rstv[1] | (32'(k) << 8) | (32'(k) << 13));
            n = 0;
            for (i = 0; i < 10; i++) begin
                wr_burst_active <= (i < 3);
                @(posedge clk);
                n += (oe === 1'b1);
            end
            chk("oe cycles", 3 + k, n);
            wr_cmd_in <= 1'b1;
            @(posedge clk);
            wr_cmd_in <= 1'b0;
            for (i = 0; i < 10 && wcmd_out !== 1'b1; i++) @(posedge clk);
            tmo(i, 10);
            if (k == 0) m = i;
        end
        chk("cmd delay", 32'h1, i - m);
        $display("test write path done");
        bus(1'b1, adr[2], 32'h3000_0100);
        for (i = 0; i < 600 && recal !== 1'b1; i++) @(posedge clk);
        tmo(i, 600);
        @(posedge clk);
        for (n = 1; n < 600 && recal !== 1'b1; n++) @(posedge clk);
        chk("recal period", 256, n);
        bus(1'b1, adr[2], 32'h3400_0100);
        repeat (4) @(posedge clk);
        chk("dll start", 32'h3, dst);
        n = 0;
        for (i = 0; i < 700; i++) begin
            @(posedge clk);
            n += (recal === 1'b1);
        end
        chk("recal off", 32'h0, n);
        $display("test recalibration done");
        @(posedge clk);
        summarize();
    end
endmodule
